/* File: shared/rstirq_pkg.sv */
`default_nettype none

package rstirq_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] MASK_OFF = 4'h1;
  localparam logic [3:0] FLAG_OFF = 4'h2;
  localparam logic [3:0] STAT_OFF = 4'h3;

  // Control register fields
  localparam int CTRL_GDIS_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;

  // Interrupt flag and mask fields
  localparam int IRQ_N = 3;
  localparam int IRQ_ONE_BIT = 0;
  localparam int IRQ_TWO_BIT = 1;
  localparam int IRQ_THREE_BIT = 2;

  // Status register fields
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;
  localparam int STAT_NMI_BIT = 2;
  localparam int STAT_CMODE_LSB = 3;
  localparam int STAT_BOOT_BIT = 5;

  // Reset values
  localparam logic GDIS_RST = 1'b1;
  localparam logic MODE_RST = 1'b0;
  localparam logic [IRQ_N-1:0] MASK_RST = 3'h0;
  localparam logic [IRQ_N-1:0] FLAG_RST = 3'h0;

  // Pin synchroniser lanes
  localparam int SYNC_N = 9;
  localparam logic [SYNC_N-1:0] SYNC_RST = 9'h1ff;
  localparam int LN_RST = 0;
  localparam int LN_NMI = 1;
  localparam int LN_IRQ1 = 2;
  localparam int LN_IRQ2 = 3;
  localparam int LN_IRQ3 = 4;
  localparam int LN_FLOAT = 5;
  localparam int LN_BOOT = 6;
  localparam int LN_SELA = 7;
  localparam int LN_SELB = 8;

  // Timing counts in system clock cycles
  localparam int RESTART_CYCLES = 16;
  localparam logic [4:0] RESTART_CNT = 5'(RESTART_CYCLES - 1);
  localparam int MCLK_HALF_CYCLES = 1;
  localparam logic [1:0] MCLK_HALF_CNT = 2'(MCLK_HALF_CYCLES - 1);

  // Interrupt identifiers
  localparam logic [1:0] IRQ_ID_NONE = 2'h0;
  localparam logic [1:0] IRQ_ID_ONE = 2'h1;
  localparam logic [1:0] IRQ_ID_TWO = 2'h2;
  localparam logic [1:0] IRQ_ID_THREE = 2'h3;

  // Restart sequencer states
  typedef enum logic [1:0] {
    ST_HALT,
    ST_WAIT,
    ST_BOOT,
    ST_RUN
  } rstirq_state_e;

endpackage

`default_nettype wire

/* File: verilog/rstirq_sync.sv */
`default_nettype none

module rstirq_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Raw and settled levels
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] level_out
);

  genvar i;

  // Three stages per lane, a change counts once stages two and three agree
  generate
    for (i = 0; i < WIDTH; i++) begin : g_lane
      logic s1_reg, s2_reg, s3_reg, lvl_reg;
      logic s1_next, s2_next, s3_next, lvl_next;
      always_comb begin
        s1_next = raw_in[i];
        s2_next = s1_reg;
        s3_next = s2_reg;
        lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
      end
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          s1_reg <= RST_VAL[i];
          s2_reg <= RST_VAL[i];
          s3_reg <= RST_VAL[i];
          lvl_reg <= RST_VAL[i];
        end else begin
          s1_reg <= s1_next;
          s2_reg <= s2_next;
          s3_reg <= s3_next;
          lvl_reg <= lvl_next;
        end
      end
      assign level_out[i] = lvl_reg;
    end
  endgenerate

endmodule

`default_nettype wire

/* File: verilog/rstirq_top.sv */
// Local design decisions: the address-and-strobe port and the placing of the registers.
`default_nettype none

// Overview of operation
// - Reset held: halt core, clear program counter
// - After release wait 16 cycles, fetch address 0
// - Boot high: run straight from off-chip memory
// - Boot low: loader copies global data to program RAM
// - NMI traps ignoring global disable and mask
// - Shared hold/one pin always raises an interrupt flag
// - Mode 0: pin is hold request with idle
// - Reset clears mode bit to hold mode
// - Two and three prioritised, masked, globally disabled
// - Flags readable and software clearable
// - Timer underflow makes a pulse on timer pin
// - Timer pulse lasts one master clock period
// - Float input low tristates timer pin
// - Master clock high in logic phase, low latch
// - Hold entered: float buses, assert release ack
module rstirq_top (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  // Register port
  input wire logic [rstirq_pkg::ADDR_W-1:0] ADDR_IN,
  input wire logic [rstirq_pkg::DATA_W-1:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [rstirq_pkg::DATA_W-1:0] RDATA_OUT,
  // Device pins
  input wire logic RESET_INPUT_N_IN,
  input wire logic BOOT_MODE_IN,
  input wire logic NMI_N_IN,
  input wire logic EXT_IRQ_ONE_N_IN,
  input wire logic EXT_IRQ_TWO_N_IN,
  input wire logic EXT_IRQ_THREE_N_IN,
  input wire logic FLOAT_N_IN,
  input wire logic CLOCK_MODE_SEL_A_IN,
  input wire logic CLOCK_MODE_SEL_B_IN,
  output logic TIMER_PULSE_OUT,
  output logic TIMER_PULSE_OE_OUT,
  output logic MASTER_CLOCK_OUT,
  output logic BUS_RELEASE_ACK_OUT,
  // Core side
  input wire logic TIMER_UNDERFLOW_IN,
  input wire logic IDLE_ACTIVE_IN,
  input wire logic BOOT_DONE_IN,
  input wire logic IRQ_ACK_IN,
  input wire logic NMI_ACK_IN,
  output logic CORE_HALT_OUT,
  output logic PC_CLEAR_OUT,
  output logic FETCH_START_OUT,
  output logic BOOT_LOADER_RUN_OUT,
  output logic OFFCHIP_RUN_OUT,
  output logic NMI_TRAP_OUT,
  output logic IRQ_REQ_OUT,
  output logic [1:0] IRQ_ID_OUT,
  output logic BUS_FLOAT_OUT,
  output logic [1:0] CLOCK_MODE_OUT
);

  import rstirq_pkg::*;

  logic [SYNC_N-1:0] pin_raw;
  logic [SYNC_N-1:0] pin_lvl;
  logic [SYNC_N-1:0] pin_prev_reg, pin_prev_next;
  logic [SYNC_N-1:0] pin_fall;
  logic dev_rst;

  // Pin lanes gathered for the synchroniser
  assign pin_raw[LN_RST] = RESET_INPUT_N_IN;
  assign pin_raw[LN_NMI] = NMI_N_IN;
  assign pin_raw[LN_IRQ1] = EXT_IRQ_ONE_N_IN;
  assign pin_raw[LN_IRQ2] = EXT_IRQ_TWO_N_IN;
  assign pin_raw[LN_IRQ3] = EXT_IRQ_THREE_N_IN;
  assign pin_raw[LN_FLOAT] = FLOAT_N_IN;
  assign pin_raw[LN_BOOT] = BOOT_MODE_IN;
  assign pin_raw[LN_SELA] = CLOCK_MODE_SEL_A_IN;
  assign pin_raw[LN_SELB] = CLOCK_MODE_SEL_B_IN;

  rstirq_sync #(
    .WIDTH(SYNC_N),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RST_N_IN),
    .raw_in(pin_raw),
    .level_out(pin_lvl)
  );

  // Falling edges of settled pin levels
  assign pin_prev_next = pin_lvl;
  assign pin_fall = pin_prev_reg & ~pin_lvl;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      pin_prev_reg <= SYNC_RST;
    end else begin
      pin_prev_reg <= pin_prev_next;
    end
  end

  // Device reset from system reset or settled reset pin
  assign dev_rst = !RST_N_IN || !pin_lvl[LN_RST];

  // Restart sequencer
  rstirq_state_e state_reg, state_next;
  logic [4:0] wait_cnt_reg, wait_cnt_next;
  logic halt_reg, halt_next;
  logic pc_clr_reg, pc_clr_next;
  logic fetch_reg, fetch_next;
  logic loader_reg, loader_next;
  logic offchip_reg, offchip_next;
  logic [1:0] cmode_reg, cmode_next;

  always_comb begin
    state_next = state_reg;
    wait_cnt_next = wait_cnt_reg;
    fetch_next = 1'b0;
    cmode_next = cmode_reg;
    case (state_reg)
      ST_HALT: begin
        wait_cnt_next = 5'h00;
        state_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (wait_cnt_reg == RESTART_CNT) begin
          fetch_next = 1'b1;
          state_next = pin_lvl[LN_BOOT] ? ST_RUN : ST_BOOT;
        end else begin
          wait_cnt_next = wait_cnt_reg + 5'h01;
        end
      end
      ST_BOOT: begin
        if (BOOT_DONE_IN) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
    halt_next = (state_next == ST_HALT) || (state_next == ST_WAIT);
    pc_clr_next = halt_next;
    loader_next = (state_next == ST_BOOT);
    offchip_next = (state_next == ST_RUN) && pin_lvl[LN_BOOT];
    if (dev_rst) begin
      cmode_next = {pin_lvl[LN_SELB], pin_lvl[LN_SELA]};
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (dev_rst) begin
      state_reg <= ST_HALT;
      wait_cnt_reg <= 5'h00;
      halt_reg <= 1'b1;
      pc_clr_reg <= 1'b1;
      fetch_reg <= 1'b0;
      loader_reg <= 1'b0;
      offchip_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wait_cnt_reg <= wait_cnt_next;
      halt_reg <= halt_next;
      pc_clr_reg <= pc_clr_next;
      fetch_reg <= fetch_next;
      loader_reg <= loader_next;
      offchip_reg <= offchip_next;
    end
  end

  // Clock mode capture, follows the pins only while reset is held
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      cmode_reg <= 2'h3;
    end else begin
      cmode_reg <= cmode_next;
    end
  end

  // Software registers and interrupt state
  logic gdis_reg, gdis_next;
  logic mode_reg, mode_next;
  logic [IRQ_N-1:0] mask_reg, mask_next;
  logic [IRQ_N-1:0] flag_reg, flag_next;
  logic [IRQ_N-1:0] flag_set, flag_clr, pend;
  logic nmi_reg, nmi_next;
  logic irq_req_reg, irq_req_next;
  logic [1:0] irq_id_reg, irq_id_next;
  logic hold_reg, hold_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic wr_ctrl, wr_mask, wr_flag;

  // Write decode
  always_comb begin
    wr_ctrl = 1'b0;
    wr_mask = 1'b0;
    wr_flag = 1'b0;
    if (WR_IN && ADDR_IN == CTRL_OFF) begin
      wr_ctrl = 1'b1;
    end else if (WR_IN && ADDR_IN == MASK_OFF) begin
      wr_mask = 1'b1;
    end else if (WR_IN && ADDR_IN == FLAG_OFF) begin
      wr_flag = 1'b1;
    end
  end

  // Flag set, clear and prioritised request
  always_comb begin
    flag_set = '0;
    flag_set[IRQ_ONE_BIT] = pin_fall[LN_IRQ1];
    flag_set[IRQ_TWO_BIT] = pin_fall[LN_IRQ2];
    flag_set[IRQ_THREE_BIT] = pin_fall[LN_IRQ3];
    flag_clr = wr_flag ? WDATA_IN[IRQ_N-1:0] : '0;
    if (IRQ_ACK_IN && irq_req_reg) begin
      flag_clr[irq_id_reg - 2'h1] = 1'b1;
    end
    flag_next = (flag_reg & ~flag_clr) | flag_set; // set beats clear
    gdis_next = wr_ctrl ? WDATA_IN[CTRL_GDIS_BIT] : gdis_reg;
    mode_next = wr_ctrl ? WDATA_IN[CTRL_MODE_BIT] : mode_reg;
    mask_next = wr_mask ? WDATA_IN[IRQ_N-1:0] : mask_reg;
    pend = flag_reg & mask_reg & {IRQ_N{~gdis_reg}};
    irq_req_next = |pend;
    if (pend[IRQ_ONE_BIT]) begin
      irq_id_next = IRQ_ID_ONE;
    end else if (pend[IRQ_TWO_BIT]) begin
      irq_id_next = IRQ_ID_TWO;
    end else if (pend[IRQ_THREE_BIT]) begin
      irq_id_next = IRQ_ID_THREE;
    end else begin
      irq_id_next = IRQ_ID_NONE;
    end
    // Non-maskable trap, no mask or disable term
    nmi_next = pin_fall[LN_NMI] | (nmi_reg & ~NMI_ACK_IN);
    // Hold only in mode 0, entered from idle, left when pin rises
    if (mode_reg) begin
      hold_next = 1'b0;
    end else if (hold_reg) begin
      hold_next = !pin_lvl[LN_IRQ1];
    end else begin
      hold_next = IDLE_ACTIVE_IN && !pin_lvl[LN_IRQ1];
    end
  end

  // Read mux, data stand one cycle after the strobe
  always_comb begin
    rdata_next = '0;
    if (RD_IN && ADDR_IN == CTRL_OFF) begin
      rdata_next[CTRL_GDIS_BIT] = gdis_reg;
      rdata_next[CTRL_MODE_BIT] = mode_reg;
    end else if (RD_IN && ADDR_IN == MASK_OFF) begin
      rdata_next[IRQ_N-1:0] = mask_reg;
    end else if (RD_IN && ADDR_IN == FLAG_OFF) begin
      rdata_next[IRQ_N-1:0] = flag_reg;
    end else if (RD_IN && ADDR_IN == STAT_OFF) begin
      rdata_next[STAT_RUN_BIT] = !halt_reg;
      rdata_next[STAT_HOLD_BIT] = hold_reg;
      rdata_next[STAT_NMI_BIT] = nmi_reg;
      rdata_next[STAT_CMODE_LSB +: 2] = cmode_reg;
      rdata_next[STAT_BOOT_BIT] = pin_lvl[LN_BOOT];
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (dev_rst) begin
      gdis_reg <= GDIS_RST;
      mode_reg <= MODE_RST;
      mask_reg <= MASK_RST;
      flag_reg <= FLAG_RST;
      nmi_reg <= 1'b0;
      irq_req_reg <= 1'b0;
      irq_id_reg <= IRQ_ID_NONE;
      hold_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      gdis_reg <= gdis_next;
      mode_reg <= mode_next;
      mask_reg <= mask_next;
      flag_reg <= flag_next;
      nmi_reg <= nmi_next;
      irq_req_reg <= irq_req_next;
      irq_id_reg <= irq_id_next;
      hold_reg <= hold_next;
      rdata_reg <= rdata_next;
    end
  end

  // Master clock divider and timer pulse
  logic [1:0] half_cnt_reg, half_cnt_next;
  logic mclk_reg, mclk_next;
  logic tpend_reg, tpend_next;
  logic timer_pulse_out_reg, timer_pulse_out_next;
  logic toe_reg, toe_next;
  logic rise_en;

  always_comb begin
    rise_en = 1'b0;
    half_cnt_next = half_cnt_reg + 2'h1;
    mclk_next = mclk_reg;
    if (half_cnt_reg == MCLK_HALF_CNT) begin
      half_cnt_next = 2'h0;
      mclk_next = !mclk_reg;
      rise_en = !mclk_reg;
    end
    tpend_next = tpend_reg | TIMER_UNDERFLOW_IN;
    timer_pulse_out_next = timer_pulse_out_reg;
    if (rise_en) begin
      timer_pulse_out_next = tpend_next;
      tpend_next = 1'b0;
    end
    toe_next = pin_lvl[LN_FLOAT];
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      half_cnt_reg <= 2'h0;
      mclk_reg <= 1'b1;
      tpend_reg <= 1'b0;
      timer_pulse_out_reg <= 1'b0;
      toe_reg <= 1'b1;
    end else begin
      half_cnt_reg <= half_cnt_next;
      mclk_reg <= mclk_next;
      tpend_reg <= tpend_next;
      timer_pulse_out_reg <= timer_pulse_out_next;
      toe_reg <= toe_next;
    end
  end

  // Outputs straight from flip-flops
  assign RDATA_OUT = rdata_reg;
  assign TIMER_PULSE_OUT = timer_pulse_out_reg;
  assign TIMER_PULSE_OE_OUT = toe_reg;
  assign MASTER_CLOCK_OUT = mclk_reg;
  assign BUS_RELEASE_ACK_OUT = hold_reg;
  assign BUS_FLOAT_OUT = hold_reg;
  assign CORE_HALT_OUT = halt_reg;
  assign PC_CLEAR_OUT = pc_clr_reg;
  assign FETCH_START_OUT = fetch_reg;
  assign BOOT_LOADER_RUN_OUT = loader_reg;
  assign OFFCHIP_RUN_OUT = offchip_reg;
  assign NMI_TRAP_OUT = nmi_reg;
  assign IRQ_REQ_OUT = irq_req_reg;
  assign IRQ_ID_OUT = irq_id_reg;
  assign CLOCK_MODE_OUT = cmode_reg;

endmodule

`default_nettype wire

/* File: bench/rstirq_top_asserts.sv */
`default_nettype none

// Port-level timing checks for the reset and interrupt block
module rstirq_checker (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  // Pins and core strobes
  input wire logic RESET_INPUT_N_IN,
  input wire logic NMI_N_IN,
  input wire logic EXT_IRQ_ONE_N_IN,
  input wire logic FLOAT_N_IN,
  input wire logic TIMER_UNDERFLOW_IN,
  // Observed outputs
  input wire logic TIMER_PULSE_OUT,
  input wire logic TIMER_PULSE_OE_OUT,
  input wire logic MASTER_CLOCK_OUT,
  input wire logic BUS_RELEASE_ACK_OUT,
  input wire logic BUS_FLOAT_OUT,
  input wire logic CORE_HALT_OUT,
  input wire logic PC_CLEAR_OUT,
  input wire logic FETCH_START_OUT,
  input wire logic NMI_TRAP_OUT
);
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RST_N_IN);

  // Clock, timer and float behaviour
  a_mclk_toggle: assert property ($past(RST_N_IN) |-> MASTER_CLOCK_OUT != $past(MASTER_CLOCK_OUT))
    else $error("master clock stuck");
  a_pulse_width: assert property ($rose(TIMER_PULSE_OUT) |-> TIMER_PULSE_OUT[*2] ##1 !TIMER_PULSE_OUT)
    else $error("timer pulse width wrong");
  a_pulse_cause: assert property (TIMER_UNDERFLOW_IN |-> ##[1:4] TIMER_PULSE_OUT)
    else $error("no timer pulse after underflow");
  a_float_oe: assert property (!FLOAT_N_IN |-> ##[1:6] !TIMER_PULSE_OE_OUT)
    else $error("timer pin still driven");
  // Restart sequencing
  a_halt_pin: assert property (!RESET_INPUT_N_IN |-> ##[1:5] (CORE_HALT_OUT && PC_CLEAR_OUT))
    else $error("core not halted in reset");
  a_restart_wait: assert property ($rose(RESET_INPUT_N_IN) |->
    !FETCH_START_OUT[*8] ##1 !FETCH_START_OUT[*8] ##[1:6] FETCH_START_OUT)
    else $error("restart wait wrong");
  a_fetch_halt: assert property (FETCH_START_OUT |->
    ($fell(CORE_HALT_OUT) && !PC_CLEAR_OUT) ##1 !FETCH_START_OUT)
    else $error("fetch start misaligned");
  // Trap and hold
  a_nmi_trap: assert property ($fell(NMI_N_IN) |-> ##[1:8] NMI_TRAP_OUT)
    else $error("no trap after nmi");
  a_hold_release: assert property (EXT_IRQ_ONE_N_IN[*5] |->
    ##1 (!BUS_RELEASE_ACK_OUT && !BUS_FLOAT_OUT))
    else $error("hold kept after pin released");

  // Main scenarios reached
  c_fetch: cover property (FETCH_START_OUT);
  c_pulse: cover property ($rose(TIMER_PULSE_OUT));
  c_hold: cover property ($rose(BUS_RELEASE_ACK_OUT));
endmodule

bind rstirq_top rstirq_checker rstirq_checker_inst (.CLK_SYS_IN, .RST_N_IN, .RESET_INPUT_N_IN,
  .NMI_N_IN, .EXT_IRQ_ONE_N_IN, .FLOAT_N_IN, .TIMER_UNDERFLOW_IN, .TIMER_PULSE_OUT,
  .TIMER_PULSE_OE_OUT,
  .MASTER_CLOCK_OUT, .BUS_RELEASE_ACK_OUT, .BUS_FLOAT_OUT, .CORE_HALT_OUT, .PC_CLEAR_OUT,
  .FETCH_START_OUT, .NMI_TRAP_OUT);

`default_nettype wire

/* File: bench/rstirq_partner.sv */
`default_nettype none

// Board side: reset pin, interrupt sources, hold requester, straps
module rstirq_partner (
  // Clock
  input wire logic clk_in,
  // Low pins: 0 reset, 1 nmi, 2 one/hold, 3 two, 4 three, 5 float
  output logic [5:0] pins_n_out,
  // Straps
  output logic boot_out,
  output logic [1:0] sel_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Reset pin starts low, the rest idle high
  initial begin
    pins_n_out = 6'h3e;
    boot_out = 1'h1;
    sel_out = 2'h2;
  end

  // Hold a line low long enough to pass the synchroniser
  task automatic press(input int idx, input int n);
    pins_n_out[idx] <= 1'h0;
    repeat (n) @(posedge clk_in);
    pins_n_out[idx] <= 1'h1;
  endtask

  // Straps move only once the reset pin is low
  task automatic enter_reset(input logic b, input logic [1:0] s);
    pins_n_out[0] <= 1'h0;
    @(posedge clk_in);
    boot_out <= b;
    sel_out <= s;
  endtask

  // Let the device out of reset
  task automatic leave_reset();
    pins_n_out[0] <= 1'h1;
  endtask
endmodule

`default_nettype wire

/* File: bench/rstirq_top_test.sv */
`default_nettype none

module rstirq_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rstirq_pkg::*;

  // Stimulus and observed signals
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic unf = 1'h0;
  logic idle = 1'h0;
  logic bdone = 1'h0;
  logic iack = 1'h0;
  logic nack = 1'h0;
  logic [5:0] pins_n;
  logic boot;
  logic [1:0] sel;
  logic [DATA_W-1:0] rdata;
  logic tp, toe, mclk, hack, halt, pcc, fetch, bl, offc, nmi, ireq, bfl;
  logic [1:0] iid, cmode;
  logic [15:0] d;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  rstirq_partner rstirq_partner_inst (.clk_in(clk), .pins_n_out(pins_n), .boot_out(boot),
    .sel_out(sel));

  rstirq_top rstirq_top_inst (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .RESET_INPUT_N_IN(pins_n[0]), .BOOT_MODE_IN(boot), .NMI_N_IN(pins_n[1]),
    .EXT_IRQ_ONE_N_IN(pins_n[2]), .EXT_IRQ_TWO_N_IN(pins_n[3]),
    .EXT_IRQ_THREE_N_IN(pins_n[4]), .FLOAT_N_IN(pins_n[5]), .CLOCK_MODE_SEL_A_IN(sel[0]),
    .CLOCK_MODE_SEL_B_IN(sel[1]), .TIMER_PULSE_OUT(tp), .TIMER_PULSE_OE_OUT(toe),
    .MASTER_CLOCK_OUT(mclk), .BUS_RELEASE_ACK_OUT(hack), .TIMER_UNDERFLOW_IN(unf),
    .IDLE_ACTIVE_IN(idle), .BOOT_DONE_IN(bdone), .IRQ_ACK_IN(iack), .NMI_ACK_IN(nack),
    .CORE_HALT_OUT(halt), .PC_CLEAR_OUT(pcc), .FETCH_START_OUT(fetch),
    .BOOT_LOADER_RUN_OUT(bl), .OFFCHIP_RUN_OUT(offc), .NMI_TRAP_OUT(nmi),
    .IRQ_REQ_OUT(ireq), .IRQ_ID_OUT(iid), .BUS_FLOAT_OUT(bfl), .CLOCK_MODE_OUT(cmode));

  // Compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Wait edges, then let outputs settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Register bus cycles
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    #1;
  endtask

  task automatic rd_reg(input logic [3:0] a);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask

  // Reset pin, restart wait, boot choice, mode capture
  task automatic t_restart(input logic b, input logic [1:0] s);
    int n;
    n = 0;
    rstirq_partner_inst.enter_reset(b, s);
    cyc(6);
    chk("halt", 16'h3, {14'h0, halt, pcc});
    rstirq_partner_inst.leave_reset();
    while (fetch !== 1'h1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk("restart", 16'h1, 16'(n >= 17 && n <= 22));
    chk("halt_end", 16'h0, {14'h0, halt, pcc});
    chk("run_mode", {14'h0, b, ~b}, {14'h0, offc, bl});
    chk("clk_mode", 16'(s), 16'(cmode));
    rd_reg(STAT_OFF);
    chk("status", {10'h0, b, s, 3'h1}, d);
    if (!b) begin
      bdone <= 1'h1;
      cyc(1);
      bdone <= 1'h0;
      cyc(2);
      chk("loader_end", 16'h0, 16'(bl));
    end
    $display("restart test done");
  endtask

  // Reset values and an unmapped place
  task automatic t_regs();
    rd_reg(CTRL_OFF);
    chk("ctrl", 16'h1, d);
    rd_reg(MASK_OFF);
    chk("mask", 16'h0, d);
    wr_reg(4'h9, 16'hffff);
    rd_reg(4'h9);
    chk("unmapped", 16'h0, d);
    $display("register test done");
  endtask

  // Priority, ack, clear, global disable, mask
  task automatic t_irq();
    wr_reg(MASK_OFF, 16'h6);
    wr_reg(CTRL_OFF, 16'h0);
    fork
      rstirq_partner_inst.press(4, 6);
      rstirq_partner_inst.press(3, 6);
    join
    cyc(4);
    rd_reg(FLAG_OFF);
    chk("flags", 16'h6, d);
    chk("irq_two", 16'h6, {13'h0, ireq, iid});
    iack <= 1'h1;
    cyc(1);
    iack <= 1'h0;
    cyc(2);
    chk("irq_three", 16'h7, {13'h0, ireq, iid});
    wr_reg(FLAG_OFF, 16'h4);
    cyc(2);
    chk("irq_none", 16'h0, {13'h0, ireq, iid});
    wr_reg(CTRL_OFF, 16'h1);
    rstirq_partner_inst.press(3, 6);
    cyc(4);
    chk("gdis", 16'h0, 16'(ireq));
    wr_reg(CTRL_OFF, 16'h0);
    cyc(2);
    chk("enable", 16'h6, {13'h0, ireq, iid});
    wr_reg(MASK_OFF, 16'h4);
    cyc(2);
    chk("masked", 16'h0, 16'(ireq));
    wr_reg(FLAG_OFF, 16'h7);
    $display("interrupt test done");
  endtask

  // Trap with everything disabled and masked
  task automatic t_nmi();
    wr_reg(CTRL_OFF, 16'h1);
    wr_reg(MASK_OFF, 16'h0);
    rstirq_partner_inst.press(1, 6);
    cyc(4);
    chk("nmi", 16'h1, 16'(nmi));
    nack <= 1'h1;
    cyc(1);
    nack <= 1'h0;
    cyc(2);
    chk("nmi_ack", 16'h0, 16'(nmi));
    $display("nmi test done");
  endtask

  // Shared pin in both modes
  task automatic t_hold();
    idle <= 1'h1;
    rstirq_partner_inst.press(2, 8);
    cyc(0);
    chk("hold", 16'h3, {14'h0, hack, bfl});
    cyc(6);
    chk("unhold", 16'h0, {14'h0, hack, bfl});
    rd_reg(FLAG_OFF);
    chk("flag_one", 16'h1, d);
    wr_reg(FLAG_OFF, 16'h1);
    wr_reg(CTRL_OFF, 16'h3);
    rstirq_partner_inst.press(2, 8);
    cyc(0);
    chk("no_hold", 16'h0, {14'h0, hack, bfl});
    rd_reg(FLAG_OFF);
    chk("flag_one_m1", 16'h1, d);
    wr_reg(FLAG_OFF, 16'h1);
    idle <= 1'h0;
    $display("hold test done");
  endtask

  // Underflow pulse and float
  task automatic t_timer();
    int n;
    n = 0;
    unf <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      unf <= 1'h0;
      if (tp === 1'h1 && n == 0) chk("phase", 16'h1, 16'(mclk));
      n += int'(tp === 1'h1);
    end
    chk("width", 16'h2, 16'(n));
    fork
      rstirq_partner_inst.press(5, 10);
      begin
        cyc(8);
        chk("float", 16'h0, 16'(toe));
      end
    join
    cyc(6);
    chk("drive", 16'h1, 16'(toe));
    $display("timer test done");
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      end_sim();
    end
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    cyc(1);
    t_restart(1'h1, 2'h2);
    t_regs();
    t_irq();
    t_nmi();
    t_hold();
    t_timer();
    t_restart(1'h0, 2'h1);
    end_sim();
  end
endmodule

`default_nettype wire
